// file: inc/iec_pkg.sv
// constants shared by the input-event capture block and its measurement unit
// assumes a single 100 MHz clock and byte-addressed 32-bit register words
package iec_pkg;

    // ------------------------------------------------------------
    // clock and measurement timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int MEAS_UNIT_NS  = 1000;   // readouts in whole microseconds
    localparam int MEAS_UNIT_CYC = MEAS_UNIT_NS / CLK_PERIOD_NS;
    localparam int DIV_W         = $clog2(MEAS_UNIT_CYC + 1);

    // ------------------------------------------------------------
    // channel counts and pin groups
    // ------------------------------------------------------------
    localparam int NUM_PINS = 16;
    localparam int NUM_MEAS = 6;
    localparam int NUM_CTR  = 3;
    localparam logic [15:0] INT_CAPABLE = 16'h0F3F;   // inputs 1-6 and 9-12

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL        = 8'h00;
    localparam logic [7:0] OFF_IN_IMAGE    = 8'h04;
    localparam logic [7:0] OFF_OUT_IMAGE   = 8'h08;
    localparam logic [7:0] OFF_INT_DEFINE  = 8'h0C;
    localparam logic [7:0] OFF_INT_EDGE    = 8'h10;
    localparam logic [7:0] OFF_INT_STATUS  = 8'h14;
    localparam logic [7:0] OFF_INT_MASK    = 8'h18;
    localparam logic [7:0] OFF_CTR_DEFINE  = 8'h1C;
    localparam logic [7:0] OFF_PM_ENABLE   = 8'h20;
    localparam logic [7:0] OFF_CTR_BASE    = 8'h24;
    localparam logic [7:0] OFF_WIDTH_BASE  = 8'h30;
    localparam logic [7:0] OFF_PERIOD_BASE = 8'h48;
    localparam logic [7:0] REG_STRIDE      = 8'h04;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_REFRESH_BIT = 0;
    localparam logic [15:0] RST_OUT_IMAGE = 16'h0000;
    localparam logic [15:0] RST_INT_EDGE  = 16'hFFFF;   // rising edge
    localparam logic [15:0] RST_INT_MASK  = 16'h0000;

endpackage

// file: inc/iec_meas_if.sv
// bundle between the event block and its pulse measurement unit
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface iec_meas_if #(
    parameter int N = 6,
    parameter int W = 16
);
    logic [N-1:0]        level;    // synchronised input levels
    logic [N-1:0]        enable;   // measurement active per input
    logic [N-1:0][W-1:0] width;    // last high time, microseconds
    logic [N-1:0][W-1:0] period;   // last rise-to-rise time, microseconds

    modport meas (input level, input enable, output width, output period);
    modport ctl  (output level, output enable, input width, input period);
endinterface

// file: rtl/iec_pulse_meas.sv
// pulse width and period measurement, one channel per shared input
// assumes levels already synchronised to ref_clk by the caller
`timescale 1ns/10ps
module iec_pulse_meas
    import iec_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    iec_meas_if.meas mif
);
    import iec_pkg::*;

    localparam int N = $bits(mif.level);
    localparam int W = $bits(mif.width) / N;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic         prev;
        logic         armed;
        logic [W-1:0] high;
        logic [W-1:0] per;
        logic [W-1:0] width;
        logic [W-1:0] period;
    } iec_ch_t;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic             tick;
        iec_ch_t [N-1:0]  ch;
    } iec_meas_t;

    iec_meas_t st;
    iec_meas_t next_st;
    iec_ch_t   chNext [N];

    // ------------------------------------------------------------
    // per-channel measurement
    // ------------------------------------------------------------
    // counters saturate so an interval past their range, once its closing edge comes, reads as the longest time
    // rather than wrapping to a small, plausible value
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_ch
            always_comb
            begin
                chNext[gi] = st.ch[gi];
                chNext[gi].prev = mif.level[gi];
                if (!mif.enable[gi])
                begin
                    chNext[gi].armed = 1'b0;
                    chNext[gi].high = '0;
                    chNext[gi].per = '0;
                end
                else
                begin
                    // microsecond resolution from the divider tick
                    if (st.tick && st.ch[gi].per != '1)
                        chNext[gi].per = st.ch[gi].per + 1'b1;
                    if (st.tick && mif.level[gi] && st.ch[gi].high != '1)
                        chNext[gi].high = st.ch[gi].high + 1'b1;
                    // first rise only arms, so a partial period is never reported
                    if (mif.level[gi] && !st.ch[gi].prev)
                    begin
                        if (st.ch[gi].armed)
                            chNext[gi].period = st.ch[gi].per;
                        chNext[gi].armed = 1'b1;
                        // the edge cycle's own tick counts, so a window of whole
                        // microseconds never loses one to the divider phase
                        chNext[gi].per = W'(st.tick);
                        chNext[gi].high = W'(st.tick);
                    end
                    if (!mif.level[gi] && st.ch[gi].prev && st.ch[gi].armed)
                        chNext[gi].width = st.ch[gi].high;
                end
            end
            assign mif.width[gi]  = st.ch[gi].width;
            assign mif.period[gi] = st.ch[gi].period;
        end
    endgenerate

    // ------------------------------------------------------------
    // microsecond divider and assembly
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        next_st.div = st.div + 1'b1;
        if (st.div == DIV_W'(MEAS_UNIT_CYC - 1))
        begin
            next_st.div = '0;
            next_st.tick = 1'b1;
        end
        for (int i = 0; i < N; i++)
            next_st.ch[i] = chNext[i];
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            st <= '0;
        else
            st <= next_st;
    end

endmodule

// file: rtl/iec_input_event.sv
// input-event capture: scan-time I/O images, edge interrupts, quadrature
// counters and the arbitration of shared inputs 1-6 between functions
// assumes asynchronous input pins and a single-cycle register port master
//
// Functional notes
// - counter define also enables measurement on pair
// - counting and measuring run side by side
// - measurement enable never turns counter on
// - measurement enable drops an active counter
// - refresh updates input image and outputs together
// - outputs change only at refresh
// - interrupt inputs trigger on edges
// - inputs 1-6 and 9-12 interrupt capable
// - per-input rising or falling edge select
// - detected edge raises interrupt at once
// - pulse width accurate up to 4 kHz
// - interrupt input loses counter and measurement roles
// - readouts in whole microseconds
`timescale 1ns/10ps
module iec_input_event #(
    parameter int CNT_W  = 16,
    parameter int MEAS_W = 16
)(
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    input  wire logic [7:0]           regAddr,
    input  wire logic [31:0]          regWdata,
    input  wire logic                 regWr,
    input  wire logic                 regRd,
    output logic [31:0]               regRdata,
    input  wire logic [iec_pkg::NUM_PINS-1:0] pinIn,
    output logic [iec_pkg::NUM_PINS-1:0] pinOut,
    output logic                      irq
);
    import iec_pkg::*;

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    generate
        if (CNT_W < 2 || CNT_W > 32)
        begin : g_bad_cnt
            $error("CNT_W must lie between 2 and 32");
        end
        if (MEAS_W < 8 || MEAS_W > 32)
        begin : g_bad_meas
            $error("MEAS_W must lie between 8 and 32");
        end
    endgenerate

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_PINS-1:0]            syncA;
        logic [NUM_PINS-1:0]            syncB;
        logic [NUM_PINS-1:0]            prevIn;
        logic [NUM_PINS-1:0]            inImage;
        logic [NUM_PINS-1:0]            outImage;
        logic [NUM_PINS-1:0]            pinOut;
        logic [NUM_PINS-1:0]            intDef;
        logic [NUM_PINS-1:0]            intEdge;
        logic [NUM_PINS-1:0]            intStatus;
        logic [NUM_PINS-1:0]            intMask;
        logic [NUM_CTR-1:0]             ctrEn;
        logic [NUM_MEAS-1:0]            pmEn;
        logic [NUM_CTR-1:0][CNT_W-1:0]  ctr;
        logic [31:0]                    rdata;
        logic                           irq;
    } iec_state_t;

    iec_state_t st;
    iec_state_t next_st;

    // ------------------------------------------------------------
    // measurement unit
    // ------------------------------------------------------------
    iec_meas_if #(.N(NUM_MEAS), .W(MEAS_W)) measBus ();

    // measurement watches the same synchronised levels as the counters,
    // so both functions share one input without interfering
    assign measBus.level  = st.syncB[NUM_MEAS-1:0];
    assign measBus.enable = st.pmEn;

    iec_pulse_meas u_meas (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .mif     (measBus)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic [NUM_PINS-1:0] rise;
        logic [NUM_PINS-1:0] fall;
        logic [NUM_PINS-1:0] evt;
        logic [NUM_PINS-1:0] newInt;
        logic                chA;
        logic                chB;
        rise = '0;
        fall = '0;
        evt = '0;
        newInt = '0;
        chA = 1'b0;
        chB = 1'b0;
        next_st = st;

        // two-stage synchroniser, edges compare stage two with history
        next_st.syncA = pinIn;
        next_st.syncB = st.syncA;
        next_st.prevIn = st.syncB;
        rise = st.syncB & ~st.prevIn;
        fall = ~st.syncB & st.prevIn;

        // edges, not levels, so a pulse shorter than a scan still counts
        evt = st.intDef & ((st.intEdge & rise) | (~st.intEdge & fall));
        // for the per-input polarity above

        // a read clears status, but an edge in the same cycle survives
        if (regRd && regAddr == OFF_INT_STATUS)
            next_st.intStatus = evt;
        else
            next_st.intStatus = st.intStatus | evt;

        // simple quadrature: A rising with B low counts up, B rising
        // with A low counts down; single-phase use falls out for free
        for (int c = 0; c < NUM_CTR; c++)
        begin
            chA = st.syncB[2*c];
            chB = st.syncB[2*c+1];
            if (st.ctrEn[c])
            begin
                if (rise[2*c] && !chB)
                    next_st.ctr[c] = st.ctr[c] + 1'b1;
                else if (rise[2*c+1] && !chA)
                    next_st.ctr[c] = st.ctr[c] - 1'b1;
            end
        end

        // register writes
        if (regWr)
        begin
            if (regAddr == OFF_CTRL)
            begin
                if (regWdata[CTRL_REFRESH_BIT])
                begin
                    // end of scan: sample inputs and drive outputs together
                    next_st.inImage = st.syncB;
                    next_st.pinOut = st.outImage;
                end
            end
            else if (regAddr == OFF_OUT_IMAGE)
            begin
                // held here until the next refresh
                next_st.outImage = regWdata[NUM_PINS-1:0];
            end
            else if (regAddr == OFF_INT_DEFINE)
            begin
                next_st.intDef = regWdata[NUM_PINS-1:0] & INT_CAPABLE;
                newInt = next_st.intDef & ~st.intDef;
                for (int i = 0; i < NUM_MEAS; i++)
                begin
                    if (newInt[i])
                    begin
                        // an interrupt input gives up its measurement and counter roles
                        next_st.pmEn[i] = 1'b0;
                        next_st.ctrEn[i/2] = 1'b0;
                    end
                end
            end
            else if (regAddr == OFF_INT_EDGE)
            begin
                next_st.intEdge = regWdata[NUM_PINS-1:0];
            end
            else if (regAddr == OFF_INT_MASK)
            begin
                next_st.intMask = regWdata[NUM_PINS-1:0];
            end
            else if (regAddr == OFF_CTR_DEFINE)
            begin
                for (int c = 0; c < NUM_CTR; c++)
                begin
                    // refused while either input of the pair is an interrupt
                    if (regWdata[c] && st.intDef[2*c+:2] == 2'b00)
                    begin
                        next_st.ctrEn[c] = 1'b1;
                        next_st.ctr[c] = '0;
                        next_st.pmEn[2*c+:2] = 2'b11;
                    end
                end
            end
            else if (regAddr == OFF_PM_ENABLE)
            begin
                for (int i = 0; i < NUM_MEAS; i++)
                begin
                    if (regWdata[i] && !st.intDef[i])
                    begin
                        // only measurement is switched on
                        next_st.pmEn[i] = 1'b1;
                        // and it displaces a counter on that pair
                        next_st.ctrEn[i/2] = 1'b0;
                    end
                end
            end
        end

        // read data stands only in the cycle after the strobe
        next_st.rdata = '0;
        if (regRd)
        begin
            if (regAddr == OFF_IN_IMAGE)
                next_st.rdata = 32'(st.inImage);
            else if (regAddr == OFF_OUT_IMAGE)
                next_st.rdata = 32'(st.outImage);
            else if (regAddr == OFF_INT_DEFINE)
                next_st.rdata = 32'(st.intDef);
            else if (regAddr == OFF_INT_EDGE)
                next_st.rdata = 32'(st.intEdge);
            else if (regAddr == OFF_INT_STATUS)
                next_st.rdata = 32'(st.intStatus);
            else if (regAddr == OFF_INT_MASK)
                next_st.rdata = 32'(st.intMask);
            else if (regAddr == OFF_CTR_DEFINE)
                next_st.rdata = 32'(st.ctrEn);
            else if (regAddr == OFF_PM_ENABLE)
                next_st.rdata = 32'(st.pmEn);
            else
            begin
                for (int c = 0; c < NUM_CTR; c++)
                begin
                    if (regAddr == OFF_CTR_BASE + 8'(c) * REG_STRIDE)
                        next_st.rdata = 32'(st.ctr[c]);
                end
                for (int i = 0; i < NUM_MEAS; i++)
                begin
                    if (regAddr == OFF_WIDTH_BASE + 8'(i) * REG_STRIDE)
                        next_st.rdata = 32'(measBus.width[i]);
                    else if (regAddr == OFF_PERIOD_BASE + 8'(i) * REG_STRIDE)
                        next_st.rdata = 32'(measBus.period[i]);
                end
            end
        end

        // interrupt follows pending bits straight away, no scan delay
        next_st.irq = |(next_st.intStatus & st.intMask);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '0;
            st.outImage <= RST_OUT_IMAGE;
            st.pinOut <= RST_OUT_IMAGE;
            st.intEdge <= RST_INT_EDGE;
            st.intMask <= RST_INT_MASK;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------
    assign regRdata = st.rdata;
    assign pinOut   = st.pinOut;
    assign irq      = st.irq;

endmodule

// file: dv/iec_sensor_model.sv
// sensor side of the input pins: levels held for a set number of clocks
// assumes the bench calls drive just after a rising edge of ref_clk
`timescale 1ns/10ps
module iec_sensor_model
(
    input  wire logic                         ref_clk,
    output logic [iec_pkg::NUM_PINS-1:0]      pins
);
    import iec_pkg::*;

    initial pins = '0;

    // ------------------------------------------------------------
    // level driver
    // ------------------------------------------------------------
    // a plain input is only seen if held across a whole scan
    task automatic drive(input logic [NUM_PINS-1:0] lvl, input int cycles);
        pins <= lvl;
        repeat (cycles) @(posedge ref_clk);
        #1;
    endtask
endmodule

// file: dv/iec_input_event_assertions.sv
// concurrent checks on the register port, output pins and interrupt line
// assumes a master that never raises both strobes in one cycle
`timescale 1ns/10ps
module iec_input_event_assertions
(
    input wire logic                          ref_clk,
    input wire logic                          rst_b,
    input wire logic [7:0]                    regAddr,
    input wire logic [31:0]                   regWdata,
    input wire logic                          regWr,
    input wire logic                          regRd,
    input wire logic [31:0]                   regRdata,
    input wire logic [iec_pkg::NUM_PINS-1:0]  pinIn,
    input wire logic [iec_pkg::NUM_PINS-1:0]  pinOut,
    input wire logic                          irq
);
    import iec_pkg::*;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------
    // bus steps
    // ------------------------------------------------------------
    sequence s_wr(logic [7:0] a);
        regWr && regAddr == a;
    endsequence
    sequence s_rd(logic [7:0] a);
        regRd && regAddr == a;
    endsequence
    sequence s_refresh;
        regWr && regAddr == OFF_CTRL && regWdata[CTRL_REFRESH_BIT];
    endsequence

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_out_hold;
        $changed(pinOut) |-> $past(regWr && regAddr == OFF_CTRL && regWdata[CTRL_REFRESH_BIT]);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("pins moved without refresh");

    property p_refresh_drive;
        s_wr(OFF_OUT_IMAGE) ##1 s_refresh |=> pinOut == $past(regWdata[15:0], 2);
    endproperty
    a_refresh_drive: assert property (p_refresh_drive) else $error("refresh lost image");

    property p_out_back;
        s_wr(OFF_OUT_IMAGE) ##1 s_rd(OFF_OUT_IMAGE)
            |=> regRdata == {16'h0000, $past(regWdata[15:0], 2)};
    endproperty
    a_out_back: assert property (p_out_back) else $error("output image readback");

    property p_int_def_back;
        s_wr(OFF_INT_DEFINE) ##1 s_rd(OFF_INT_DEFINE)
            |=> regRdata == {16'h0000, $past(regWdata[15:0], 2) & INT_CAPABLE};
    endproperty
    a_int_def_back: assert property (p_int_def_back) else $error("interrupt select readback");

    property p_int_def_range;
        s_rd(OFF_INT_DEFINE) |=> (regRdata & ~{16'h0000, INT_CAPABLE}) == 32'h0;
    endproperty
    a_int_def_range: assert property (p_int_def_range) else $error("bad interrupt input");

    property p_pm_drops_ctr;
        (s_wr(OFF_PM_ENABLE) ##0 regWdata[0]) ##1 s_rd(OFF_CTR_DEFINE) |=> !regRdata[0];
    endproperty
    a_pm_drops_ctr: assert property (p_pm_drops_ctr) else $error("counter kept");

    property p_int_clears_ctr;
        (s_wr(OFF_INT_DEFINE) ##0 regWdata[2]) ##1 s_rd(OFF_CTR_DEFINE) |=> !regRdata[1];
    endproperty
    a_int_clears_ctr: assert property (p_int_clears_ctr) else $error("shared counter kept");

    property p_mask_quiet;
        (s_wr(OFF_INT_MASK) ##0 regWdata[15:0] == 16'h0000) ##1 !regWr |=> !irq;
    endproperty
    a_mask_quiet: assert property (p_mask_quiet) else $error("irq with all masked");
endmodule

bind iec_input_event iec_input_event_assertions i_chk
(
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .regAddr  (regAddr),
    .regWdata (regWdata),
    .regWr    (regWr),
    .regRd    (regRd),
    .regRdata (regRdata),
    .pinIn    (pinIn),
    .pinOut   (pinOut),
    .irq      (irq)
);

// file: dv/iec_input_event_bench.sv
// self-checking bench of the input-event block with a sensor model on the pins
// assumes the package offsets and a 100 MHz ref_clk
`timescale 1ns/10ps
module iec_input_event_bench;
    import iec_pkg::*;

    typedef struct packed { logic wr; logic [7:0] a; logic [31:0] d; } iec_row_t;
    localparam logic [7:0] OFF_NONE = 8'hFC;

    logic         ref_clk  = 1'b0;
    logic         rst_b    = 1'b0;
    logic [7:0]   regAddr  = 8'h00;
    logic [31:0]  regWdata = 32'h0;
    logic         regWr    = 1'b0;
    logic         regRd    = 1'b0;
    logic [31:0]  regRdata;
    logic [15:0]  pinIn;
    logic [15:0]  pinOut;
    logic         irq;
    logic [31:0]  rd;
    int           errors      = 0;
    int           check_count = 0;
    iec_row_t     rowTab [30];

    always #5 ref_clk = ~ref_clk;

    iec_input_event i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .pinIn(pinIn), .pinOut(pinOut), .irq(irq));
    iec_sensor_model i_sensor (.ref_clk(ref_clk), .pins(pinIn));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one strobe cycle; read data is taken in the cycle after the strobe
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        regWr    <= wr;
        regRd    <= !wr;
        regAddr  <= a;
        regWdata <= d;
        @(posedge ref_clk);
        #1;
        rd = regRdata;
    endtask

    task automatic idle();
        regWr <= 1'b0;
        regRd <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_irq(input int bound);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < bound)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check_word({31'h0, irq}, 32'h1);
        if (irq !== 1'b1)
            summarize();
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rowTab = '{'{1'b0, OFF_OUT_IMAGE, 32'h0}, '{1'b0, OFF_INT_EDGE, 32'hFFFF},
            '{1'b0, OFF_INT_MASK, 32'h0}, '{1'b0, OFF_INT_STATUS, 32'h0},
            '{1'b0, OFF_CTR_DEFINE, 32'h0}, '{1'b0, OFF_PM_ENABLE, 32'h0},
            '{1'b0, OFF_NONE, 32'h0}, '{1'b1, OFF_NONE, 32'hFFFFFFFF},
            '{1'b1, OFF_INT_DEFINE, 32'hFFFF}, '{1'b0, OFF_INT_DEFINE, 32'h0F3F},
            '{1'b1, OFF_INT_DEFINE, 32'h0}, '{1'b1, OFF_OUT_IMAGE, 32'h5A5A},
            '{1'b0, OFF_OUT_IMAGE, 32'h5A5A}, '{1'b1, OFF_IN_IMAGE, 32'hFFFF},
            '{1'b0, OFF_IN_IMAGE, 32'h0}, '{1'b1, OFF_PM_ENABLE, 32'h1},
            '{1'b0, OFF_CTR_DEFINE, 32'h0}, '{1'b1, OFF_CTR_DEFINE, 32'h1},
            '{1'b0, OFF_CTR_DEFINE, 32'h1}, '{1'b0, OFF_PM_ENABLE, 32'h3},
            '{1'b1, OFF_PM_ENABLE, 32'h1}, '{1'b0, OFF_CTR_DEFINE, 32'h0},
            '{1'b1, OFF_CTR_DEFINE, 32'h2}, '{1'b0, OFF_PM_ENABLE, 32'hF},
            '{1'b1, OFF_INT_DEFINE, 32'h4}, '{1'b0, OFF_CTR_DEFINE, 32'h0},
            '{1'b0, OFF_PM_ENABLE, 32'hB}, '{1'b1, OFF_CTR_DEFINE, 32'h2},
            '{1'b0, OFF_CTR_DEFINE, 32'h0}, '{1'b1, OFF_INT_DEFINE, 32'h0}};
        repeat (20) @(posedge ref_clk);
        #1;
        rst_b <= 1'b1;
        check_word({16'h0, pinOut}, 32'h0);
        check_word({31'h0, irq}, 32'h0);
        foreach (rowTab[i])
        begin
            bus(rowTab[i].wr, rowTab[i].a, rowTab[i].d);
            if (!rowTab[i].wr)
                check_word(rd, rowTab[i].d);
        end
        idle();
        // images move only on the refresh strobe
        i_sensor.drive(16'h1234, 4);
        bus(1'b1, OFF_OUT_IMAGE, 32'hBEEF);
        check_word({16'h0, pinOut}, 32'h0);
        bus(1'b1, OFF_CTRL, 32'h1);
        bus(1'b0, OFF_IN_IMAGE, 32'h0);
        check_word({16'h0, pinOut}, 32'hBEEF);
        check_word(rd, 32'h1234);
        idle();
        i_sensor.drive(16'h0000, 4);
        bus(1'b0, OFF_IN_IMAGE, 32'h0);
        check_word(rd, 32'h1234);
        // counting and measuring one pulse train on input 1
        bus(1'b1, OFF_CTR_DEFINE, 32'h1);
        idle();
        repeat (3)
        begin
            i_sensor.drive(16'h0001, 300);
            i_sensor.drive(16'h0000, 200);
        end
        bus(1'b0, OFF_CTR_BASE, 32'h0);
        check_word(rd, 32'h3);
        bus(1'b0, OFF_WIDTH_BASE, 32'h0);
        check_word(rd, 32'h3);
        bus(1'b0, OFF_PERIOD_BASE, 32'h0);
        check_word(rd, 32'h5);
        // edge interrupts on input 9, masked first
        bus(1'b1, OFF_INT_DEFINE, 32'h100);
        idle();
        i_sensor.drive(16'h0100, 2);
        i_sensor.drive(16'h0000, 10);
        check_word({31'h0, irq}, 32'h0);
        bus(1'b0, OFF_INT_STATUS, 32'h0);
        check_word(rd, 32'h100);
        bus(1'b1, OFF_INT_MASK, 32'h100);
        for (int m = 0; m < 2; m++)
        begin
            bus(1'b1, OFF_INT_EDGE, m ? 32'hFEFF : 32'hFFFF);
            idle();
            i_sensor.drive(16'h0100, 10);
            bus(1'b0, OFF_INT_STATUS, 32'h0);
            check_word(rd, m ? 32'h0 : 32'h100);
            idle();
            i_sensor.drive(16'h0000, 10);
            bus(1'b0, OFF_INT_STATUS, 32'h0);
            check_word(rd, m ? 32'h100 : 32'h0);
        end
        idle();
        // short pulse far below a scan still interrupts, on its falling edge
        i_sensor.drive(16'h0100, 2);
        i_sensor.drive(16'h0000, 0);
        wait_irq(12);
        // masking a pending source drops the line before any read
        bus(1'b1, OFF_INT_MASK, 32'h0);
        idle();
        idle();
        check_word({31'h0, irq}, 32'h0);
        bus(1'b0, OFF_INT_STATUS, 32'h0);
        check_word(rd, 32'h100);
        bus(1'b1, OFF_INT_MASK, 32'h100);
        idle();
        idle();
        check_word({31'h0, irq}, 32'h0);
        summarize();
    end
endmodule
